//--- bench/amd_pmem.sv
// Program memory model: one byte and one mode code per location.
// Assumes the decoder reads it combinationally in the same cycle.
`timescale 1ns/10ps
`include "amd_consts.vh"
module amd_pmem (
  input wire [11:0] prog_addr,
  output wire [7:0] prog_data,
  output wire [3:0] mode
);
  logic [7:0] mem_q [0:4095];
  logic [3:0] mtab_q [0:4095];
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem_q[i] = 8'h00;
      mtab_q[i] = `AMD_M_INH;
    end
  end
  assign prog_data = mem_q[prog_addr];
  assign mode = mtab_q[prog_addr];
  task automatic put3(input [11:0] a, input [7:0] op, b2, b3, input [3:0] m);
    mem_q[a] = op;
    mem_q[a + 12'h001] = b2;
    mem_q[a + 12'h002] = b3;
    mtab_q[a] = m;
  endtask
endmodule // amd_pmem

//--- bench/amd_sva.sv
// Checker for the addressing mode decoder, watching the top module's ports only.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/10ps
`include "amd_consts.vh"
module amd_sva (
  input wire clk,
  input wire rst_n,
  input wire [11:0] prog_addr,
  input wire exec_done,
  input wire int_req,
  input wire instr_valid,
  input wire [11:0] instr_addr,
  input wire [1:0] instr_len,
  input wire [3:0] mode_out,
  input wire [7:0] opcode_out,
  input wire [7:0] data_addr,
  input wire data_addr_valid,
  input wire [7:0] ptr_addr,
  input wire ptr_valid,
  input wire [2:0] bit_num,
  input wire [2:0] test_cond,
  input wire [11:0] branch_target
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Mode seen only in the decode pulse; 4'hf is no mode at all
  wire [3:0] m = instr_valid ? mode_out : 4'hf;
  // ------
  // Decode
  // ------
  a_dir_addr:
    assert property (m == `AMD_M_DIR |-> instr_len == 2'h2 && data_addr_valid)
    else $error("direct decode wrong");
  a_sdir_reg:
    assert property (m == `AMD_M_SDIR |-> instr_len == 2'h1 && data_addr == {6'h20, opcode_out[3:2]})
    else $error("short direct decode wrong");
  a_ext_target:
    assert property (m == `AMD_M_EXT |-> instr_len == 2'h2 && branch_target[11:8] == opcode_out[3:0])
    else $error("extended target wrong");
  a_ext_jump:
    assert property (exec_done && !int_req && mode_out == `AMD_M_EXT
      |=> prog_addr == $past(branch_target)) else $error("extended jump missed");
  a_rel_target:
    assert property (m == `AMD_M_REL |-> instr_len == 2'h1 && branch_target == (opcode_out[4] ?
      instr_addr - opcode_out[3:0] : instr_addr + opcode_out[3:0] + 12'h001))
    else $error("relative target wrong");
  a_btb_fields:
    assert property (m == `AMD_M_BTB |-> instr_len == 2'h3 && bit_num == opcode_out[7:5]
      && test_cond == {2'h0, opcode_out[4]}) else $error("bit test decode wrong");
  a_ind_ptr:
    assert property (m == `AMD_M_IND |-> instr_len == 2'h1 && ptr_valid
      && ptr_addr == {7'h40, opcode_out[4]}) else $error("pointer select wrong");
  a_inh_len:
    assert property (m == `AMD_M_INH |-> instr_len == 2'h1 && !data_addr_valid && !ptr_valid)
    else $error("inherent decode wrong");
  c_btb: cover property (m == `AMD_M_BTB);
  c_ind: cover property (m == `AMD_M_IND);
  c_ext_exec: cover property (exec_done && mode_out == `AMD_M_EXT);
endmodule // amd_sva

//--- bench/tb_top.sv
// Bench for the addressing mode decoder; it plays the execution unit itself.
// Assumes the program memory model answers in the same cycle.
`timescale 1ns/10ps
`include "amd_consts.vh"
module tb_top;
  logic clk, rst_n, exec_done, cond_true, is_call, is_ret, int_req;
  logic [11:0] int_vec;
  wire [11:0] prog_addr, instr_addr, branch_target;
  wire [7:0] prog_data, opcode_out, imm_data, data_addr, ptr_addr;
  wire [3:0] mode, mode_out;
  wire [1:0] instr_len;
  wire [2:0] bit_num, test_cond, stk_depth;
  wire instr_valid, data_addr_valid, ptr_valid, stk_ovf, int_ack;
  integer failures = 0;
  integer compares = 0;
  integer cycles = 0;
  amd_decoder DUT (.clk, .rst_n, .prog_addr, .prog_data, .mode, .exec_done, .cond_true,
    .is_call, .is_ret, .int_req, .int_vec, .instr_valid, .instr_addr, .instr_len, .mode_out,
    .opcode_out, .imm_data, .data_addr, .data_addr_valid, .ptr_addr, .ptr_valid, .bit_num,
    .test_cond, .branch_target, .stk_depth, .stk_ovf, .int_ack);
  amd_pmem pm (.prog_addr, .prog_data, .mode);
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Load before the fetch edge, then wait for the decode pulse
  task automatic go(input [11:0] a, input [7:0] op, b2, b3, input [3:0] m, input [1:0] len);
    int n;
    n = 0;
    pm.put3(a, op, b2, b3, m);
    while (instr_valid !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(instr_addr, a);
    chk(instr_len, len);
  endtask
  // Flags are {cond_true, is_call, is_ret, int_req}
  task automatic fin(input [3:0] f, input [11:0] nxt);
    @(posedge clk);
    exec_done <= 1'b1;
    {cond_true, is_call, is_ret, int_req} <= f;
    @(posedge clk);
    exec_done <= 1'b0;
    int_req <= 1'b0;
    #1;
    chk(prog_addr, nxt);
  endtask
  task automatic t_operand;
    go(12'h000, 8'h35, 8'h5a, 8'h00, `AMD_M_IMM, 2'h2);
    chk(imm_data, 8'h5a);
    fin(4'h0, 12'h002);
    go(12'h002, 8'h10, 8'hff, 8'h00, `AMD_M_DIR, 2'h2);
    chk(data_addr, 8'hff);
    fin(4'h0, 12'h004);
    go(12'h004, 8'ha0, 8'h3c, 8'h00, `AMD_M_BDIR, 2'h2);
    chk({bit_num, data_addr}, 11'h53c);
    fin(4'h0, 12'h006);
  endtask
  task automatic t_short;
    logic [11:0] p;
    for (p = 12'h006; p < 12'h00c; p++) begin
      if (p < 12'h008) begin
        go(p, {3'h0, p[0], 4'h7}, 8'h00, 8'h00, `AMD_M_IND, 2'h1);
        chk(ptr_addr, {7'h40, p[0]});
      end else begin
        go(p, {4'h0, p[1:0], 2'h0}, 8'h00, 8'h00, `AMD_M_SDIR, 2'h1);
        chk(data_addr, {6'h20, p[1:0]});
      end
      fin(4'h0, p + 12'h001);
    end
  endtask
  task automatic t_branch;
    go(12'h00c, 8'h32, 8'h00, 8'h00, `AMD_M_EXT, 2'h2);
    chk(branch_target, 12'h200);
    fin(4'h0, 12'h200);
    go(12'h200, 8'h70, 8'hc1, 8'h7f, `AMD_M_BTB, 2'h3);
    chk({bit_num, test_cond}, 6'h19);
    chk(data_addr, 8'hc1);
    fin(4'h8, 12'h280);
    go(12'h280, 8'h60, 8'h0c, 8'h80, `AMD_M_BTB, 2'h3);
    fin(4'h8, 12'h201);
    go(12'h201, 8'haf, 8'h00, 8'h00, `AMD_M_REL, 2'h1);
    chk(test_cond, 3'h5);
    fin(4'h8, 12'h211);
    go(12'h211, 8'h5f, 8'h00, 8'h00, `AMD_M_REL, 2'h1);
    fin(4'h8, 12'h202);
    go(12'h202, 8'h43, 8'h00, 8'h00, `AMD_M_REL, 2'h1);
    fin(4'h0, 12'h203);
    go(12'h203, 8'h70, 8'hc1, 8'h00, `AMD_M_BTB, 2'h3);
    fin(4'h0, 12'h206);
  endtask
  // Seven nested calls: the seventh push must be dropped
  task automatic t_stack;
    logic [11:0] p, t;
    p = 12'h206;
    for (t = 12'h300; t < 12'h370; t = t + 12'h010) begin
      go(p, 8'h33, t[7:0], 8'h00, `AMD_M_EXT, 2'h2);
      fin(4'h4, t);
      chk({stk_ovf, stk_depth}, (t == 12'h360) ? 4'he : {1'b0, t[6:4] + 3'h1});
      p = t;
    end
    go(12'h360, 8'hc6, 8'h00, 8'h00, `AMD_M_INH, 2'h1);
    fin(4'h2, 12'h342);
    go(12'h342, 8'hc5, 8'h00, 8'h00, `AMD_M_INH, 2'h1);
    fin(4'h1, int_vec);
    chk({int_ack, stk_depth}, 4'he);
    go(int_vec, 8'hc6, 8'h00, 8'h00, `AMD_M_INH, 2'h1);
    fin(4'h2, 12'h343);
    chk(stk_depth, 3'h5);
  endtask
  task automatic report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // A hang never reaches the closing report on its own
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    rst_n = 1'b0;
    exec_done = 1'b0;
    {cond_true, is_call, is_ret, int_req} = 4'h0;
    int_vec = 12'h400;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_operand();
    t_short();
    t_branch();
    t_stack();
    report_and_stop();
  end
endmodule // tb_top
bind amd_decoder amd_sva u_sva (.clk, .rst_n, .prog_addr, .exec_done, .int_req, .instr_valid,
  .instr_addr, .instr_len, .mode_out, .opcode_out, .data_addr, .data_addr_valid, .ptr_addr,
  .ptr_valid, .bit_num, .test_cond, .branch_target);

//--- src/amd_consts.vh
// Constants for the addressing mode decoder: mode codes, lengths, field positions.
// Included by amd_decoder.v and by the bench files; definitions only, no logic.
`ifndef AMD_CONSTS_VH
`define AMD_CONSTS_VH

// ----------------------------------------------------------------------
// Address space widths, return stack depth and stack pointer width
// ----------------------------------------------------------------------
`define AMD_PA_W 12
`define AMD_DA_W 8
`define AMD_STK_DEPTH 6
`define AMD_SP_W 3

// ----------------------------------------------------------------------
// Addressing mode codes on mode / mode_out
// ----------------------------------------------------------------------
`define AMD_M_IMM 4'h0
`define AMD_M_DIR 4'h1
`define AMD_M_SDIR 4'h2
`define AMD_M_EXT 4'h3
`define AMD_M_REL 4'h4
`define AMD_M_BDIR 4'h5
`define AMD_M_BTB 4'h6
`define AMD_M_IND 4'h7
`define AMD_M_INH 4'h8

// ----------------------------------------------------------------------
// Instruction lengths in bytes
// ----------------------------------------------------------------------
`define AMD_LEN1 2'h1
`define AMD_LEN2 2'h2
`define AMD_LEN3 2'h3

// ----------------------------------------------------------------------
// Data space addresses and opcode field positions
// ----------------------------------------------------------------------
`define AMD_SCRATCH_BASE 8'h80
`define AMD_PTR0_ADDR 8'h80
`define AMD_PTR1_ADDR 8'h81
`define AMD_SDIR_SEL_HI 3
`define AMD_SDIR_SEL_LO 2
`define AMD_IND_SEL_BIT 4
`define AMD_BIT_HI 7
`define AMD_BIT_LO 5
`define AMD_BTB_COND_BIT 4
`define AMD_REL_COND_HI 7
`define AMD_REL_COND_LO 5
`define AMD_REL_DIR_BIT 4
`define AMD_EXT_HI_HI 3
`define AMD_EXT_HI_LO 0

// ----------------------------------------------------------------------
// Sequencer states, one-hot
// ----------------------------------------------------------------------
`define AMD_S_OP 5'h01
`define AMD_S_B2 5'h02
`define AMD_S_B3 5'h04
`define AMD_S_DEC 5'h08
`define AMD_S_EXEC 5'h10

`endif

//--- src/amd_decoder.v
// Operand fetch, addressing mode decode, program counter and return stack.
// Assumes prog_data reflects prog_addr combinationally in the same cycle, and
// that the execution unit pulses exec_done once per issued instruction.
`timescale 1ns/10ps
`include "amd_consts.vh"

module amd_decoder #(
  parameter [11:0] RESET_PC = 12'h000
) (
  input wire clk,
  input wire rst_n,
  output wire [11:0] prog_addr,
  input wire [7:0] prog_data,
  input wire [3:0] mode,
  input wire exec_done,
  input wire cond_true,
  input wire is_call,
  input wire is_ret,
  input wire int_req,
  input wire [11:0] int_vec,
  output wire instr_valid,
  output wire [11:0] instr_addr,
  output wire [1:0] instr_len,
  output wire [3:0] mode_out,
  output wire [7:0] opcode_out,
  output wire [7:0] imm_data,
  output wire [7:0] data_addr,
  output wire data_addr_valid,
  output wire [7:0] ptr_addr,
  output wire ptr_valid,
  output wire [2:0] bit_num,
  output wire [2:0] test_cond,
  output wire [11:0] branch_target,
  output wire [2:0] stk_depth,
  output wire stk_ovf,
  output wire int_ack
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg [4:0] state_q;
  reg [11:0] pc_q;
  reg [11:0] prog_addr_q;
  reg [7:0] op_q;
  reg [7:0] b2_q;
  reg [7:0] b3_q;
  reg [3:0] mode_q;
  reg [1:0] len_q;
  reg valid_q;
  reg [7:0] imm_q;
  reg [7:0] daddr_q;
  reg daddr_v_q;
  reg [7:0] ptr_q;
  reg ptr_v_q;
  reg [2:0] bit_q;
  reg [2:0] cond_q;
  reg [11:0] tgt_q;
  wire [11:0] stk_cell [0:`AMD_STK_DEPTH-1];
  reg [2:0] sp_q;
  reg ovf_q;
  reg ack_q;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  // One-hot, so each state test reduces to a single flip-flop
  localparam [4:0] S_OP = `AMD_S_OP;
  localparam [4:0] S_B2 = `AMD_S_B2;
  localparam [4:0] S_B3 = `AMD_S_B3;
  localparam [4:0] S_DEC = `AMD_S_DEC;
  localparam [4:0] S_EXEC = `AMD_S_EXEC;

  // ----------------------------------------------------------------------
  // Length of the incoming opcode, from its mode
  // ----------------------------------------------------------------------
  reg [1:0] len_in;
  always @* begin
    case (mode)
      `AMD_M_IMM: len_in = `AMD_LEN2;
      `AMD_M_DIR: len_in = `AMD_LEN2;
      `AMD_M_EXT: len_in = `AMD_LEN2;
      `AMD_M_BDIR: len_in = `AMD_LEN2;
      `AMD_M_BTB: len_in = `AMD_LEN3;
      `AMD_M_SDIR: len_in = `AMD_LEN1;
      `AMD_M_REL: len_in = `AMD_LEN1;
      `AMD_M_IND: len_in = `AMD_LEN1;
      default: len_in = `AMD_LEN1;
    endcase
  end

  // ----------------------------------------------------------------------
  // Operand decode from the latched bytes
  // ----------------------------------------------------------------------
  wire [3:0] span = op_q[3:0];
  wire [11:0] rel_fwd = pc_q + 12'h001 + {8'h00, span};
  wire [11:0] rel_bwd = pc_q - {8'h00, span};
  wire [11:0] btb_tgt = pc_q + {{4{b3_q[7]}}, b3_q} + 12'h001;
  wire [11:0] ext_tgt = {op_q[`AMD_EXT_HI_HI:`AMD_EXT_HI_LO], b2_q};

  reg [7:0] dec_daddr;
  reg dec_dv;
  reg [7:0] dec_ptr;
  reg dec_pv;
  reg [11:0] dec_tgt;
  reg [2:0] dec_cond;
  always @* begin
    dec_daddr = 8'h00;
    dec_dv = 1'b0;
    dec_ptr = 8'h00;
    dec_pv = 1'b0;
    dec_tgt = pc_q + {10'h000, len_q};
    dec_cond = 3'h0;
    case (mode_q)
      `AMD_M_DIR: begin
        dec_daddr = b2_q;
        dec_dv = 1'b1;
      end
      `AMD_M_SDIR: begin
        // Scratch registers sit in the data space like any other byte
        dec_daddr = `AMD_SCRATCH_BASE |
          {6'h00, op_q[`AMD_SDIR_SEL_HI:`AMD_SDIR_SEL_LO]};
        dec_dv = 1'b1;
      end
      `AMD_M_EXT: dec_tgt = ext_tgt;
      `AMD_M_REL: begin
        dec_cond = op_q[`AMD_REL_COND_HI:`AMD_REL_COND_LO];
        dec_tgt = op_q[`AMD_REL_DIR_BIT] ? rel_bwd : rel_fwd;
      end
      `AMD_M_BDIR: begin
        dec_daddr = b2_q;
        dec_dv = 1'b1;
      end
      `AMD_M_BTB: begin
        dec_daddr = b2_q;
        dec_dv = 1'b1;
        dec_cond = {2'b00, op_q[`AMD_BTB_COND_BIT]};
        dec_tgt = btb_tgt;
      end
      `AMD_M_IND: begin
        dec_ptr = op_q[`AMD_IND_SEL_BIT] ? `AMD_PTR1_ADDR : `AMD_PTR0_ADDR;
        dec_pv = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Return stack read port
  // ----------------------------------------------------------------------
  // The pointer steps past the last cell only when the stack is empty, and a
  // pop is refused then, so the wrapped read is never used
  wire [2:0] sp_dec = sp_q - 3'h1;
  wire [11:0] stk_top = stk_cell[sp_dec];

  // ----------------------------------------------------------------------
  // Next program counter at the end of execution
  // ----------------------------------------------------------------------
  wire [11:0] fall_pc = pc_q + {10'h000, len_q};
  wire stk_full = (sp_q == `AMD_STK_DEPTH);
  wire stk_empty = (sp_q == 3'h0);
  wire do_call = (mode_q == `AMD_M_EXT) && is_call;
  wire do_ret = (mode_q == `AMD_M_INH) && is_ret;
  // An interrupt is not taken, nor held, at a boundary where this instruction calls or returns
  wire take_int = int_req && !do_call && !do_ret;

  reg [11:0] next_pc;
  always @* begin
    next_pc = fall_pc;
    case (mode_q)
      `AMD_M_EXT: next_pc = tgt_q;
      `AMD_M_REL: if (cond_true) next_pc = tgt_q;
      `AMD_M_BTB: if (cond_true) next_pc = tgt_q;
      `AMD_M_INH: if (do_ret && !stk_empty) next_pc = stk_top;
      default: next_pc = fall_pc;
    endcase
  end

  // ----------------------------------------------------------------------
  // Fetch and issue sequencer
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_OP;
      pc_q <= RESET_PC;
      prog_addr_q <= RESET_PC;
      op_q <= 8'h00;
      b2_q <= 8'h00;
      b3_q <= 8'h00;
      mode_q <= `AMD_M_INH;
      len_q <= `AMD_LEN1;
      valid_q <= 1'b0;
      imm_q <= 8'h00;
      daddr_q <= 8'h00;
      daddr_v_q <= 1'b0;
      ptr_q <= 8'h00;
      ptr_v_q <= 1'b0;
      bit_q <= 3'h0;
      cond_q <= 3'h0;
      tgt_q <= 12'h000;
      ack_q <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      ack_q <= 1'b0;
      case (state_q)
        S_OP: begin
          op_q <= prog_data;
          mode_q <= mode;
          len_q <= len_in;
          b2_q <= 8'h00;
          b3_q <= 8'h00;
          if (len_in == `AMD_LEN1) begin
            state_q <= S_DEC;
          end else begin
            prog_addr_q <= pc_q + 12'h001;
            state_q <= S_B2;
          end
        end
        S_B2: begin
          b2_q <= prog_data;
          if (len_q == `AMD_LEN3) begin
            prog_addr_q <= pc_q + 12'h002;
            state_q <= S_B3;
          end else begin
            state_q <= S_DEC;
          end
        end
        S_B3: begin
          b3_q <= prog_data;
          state_q <= S_DEC;
        end
        S_DEC: begin
          valid_q <= 1'b1;
          imm_q <= (mode_q == `AMD_M_IMM) ? b2_q : 8'h00;
          daddr_q <= dec_daddr;
          daddr_v_q <= dec_dv;
          ptr_q <= dec_ptr;
          ptr_v_q <= dec_pv;
          bit_q <= op_q[`AMD_BIT_HI:`AMD_BIT_LO];
          cond_q <= dec_cond;
          tgt_q <= dec_tgt;
          state_q <= S_EXEC;
        end
        S_EXEC: begin
          if (exec_done) begin
            if (take_int) begin
              pc_q <= int_vec;
              prog_addr_q <= int_vec;
              ack_q <= 1'b1;
            end else begin
              pc_q <= next_pc;
              prog_addr_q <= next_pc;
            end
            state_q <= S_OP;
          end
        end
        // A corrupted state code restarts at the opcode fetch
        default: state_q <= S_OP;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Return address stack
  // ----------------------------------------------------------------------
  // A push onto a full stack is dropped and flagged, so the oldest return
  // addresses survive; software must avoid nesting deeper than six.
  wire at_end = (state_q == S_EXEC) && exec_done;
  wire push = at_end && (do_call || take_int);
  wire pop = at_end && do_ret && !stk_empty;
  wire [11:0] push_val = do_call ? fall_pc : next_pc;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_q <= 3'h0;
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= push && stk_full;
      if (push && !stk_full) begin
        sp_q <= sp_q + 3'h1;
      end else if (pop) begin
        sp_q <= sp_dec;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `AMD_STK_DEPTH; gi = gi + 1) begin : g_stk
      // Each cell is its own register, so every element has a single driver
      reg [11:0] cell_q;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cell_q <= 12'h000;
        end else if (push && !stk_full && (sp_q == gi)) begin
          cell_q <= push_val;
        end
      end
      assign stk_cell[gi] = cell_q;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prog_addr = prog_addr_q;
  assign instr_valid = valid_q;
  assign instr_addr = pc_q;
  assign instr_len = len_q;
  assign mode_out = mode_q;
  assign opcode_out = op_q;
  assign imm_data = imm_q;
  assign data_addr = daddr_q;
  assign data_addr_valid = daddr_v_q;
  assign ptr_addr = ptr_q;
  assign ptr_valid = ptr_v_q;
  assign bit_num = bit_q;
  assign test_cond = cond_q;
  assign branch_target = tgt_q;
  assign stk_depth = sp_q;
  assign stk_ovf = ovf_q;
  assign int_ack = ack_q;

endmodule // amd_decoder
